/* verilog/orpc_top.sv */
`timescale 1ns/1ns
`default_nettype none
module orpc_top #(
	parameter int TICK_CYCLES = orpc_pkg::BASE_TICK_CYC,
	parameter int MS_TICKS    = orpc_pkg::MS_PER_TICKS
) (
	input  wire logic       clk,                 // 25 MHz clock
	input  wire logic       rstn,                // Sync reset, active low
	input  wire logic       reg_wr,              // Register write strobe
	input  wire logic [7:0] reg_addr,            // Register address
	input  wire logic [7:0] reg_wdata,           // Register write data
	output logic      [7:0] reg_rdata,           // Read data, next cycle
	input  wire logic       high_impedance_idle, // Global idle bit
	input  wire logic       ship_mode,           // Shipping mode active
	input  wire logic       mode_request_pin_n,  // Mode request, low
	input  wire logic       internal_fb,         // Internal feedback used
	input  wire logic [6:0] output_current_scale,// Percent scaling code
	input  wire logic [6:0] battery_level,       // Battery, threshold LSB
	input  wire logic       vout_below_3v,       // Output collapse
	input  wire logic       vout_over_108,       // Output overvoltage
	input  wire logic       vout_in_reg,         // Output in regulation
	input  wire logic       vout_below_6v,       // Output under 6 V
	input  wire logic       buck_mode,           // Converter in buck
	input  wire logic       vbat_above_vin,      // Battery >= input+0.5V
	input  wire logic       load_below_5ma,      // Load under 5 mA
	input  wire logic       out_current_over,    // Output limit reached
	input  wire logic       batt_current_over,   // Battery limit reached
	output logic            reverse_active,      // In reverse-power mode
	output logic            converter_enable,    // Power stage enabled
	output logic            switching_enable,    // Switching allowed
	output logic            soft_start_active,   // Soft start running
	output logic      [9:0] vref_code,           // Ramped reference code
	output logic      [6:0] current_scale_pct,   // Effective limit, %
	output logic      [1:0] battery_limit_sel,   // Battery limit setting
	output logic      [8:0] cord_comp_mv,        // Comp at 2.4 A, mV
	output logic            ramp_sink_on,        // 70 mA sink enable
	output logic            ov_pulldown_on       // Overvoltage pulldown
);
	localparam int TW = 15;

	generate
		if (TICK_CYCLES < 1 || MS_TICKS < 1) begin : g_bad
			$error("orpc_top: tick counts must be at least 1");
		end
	endgenerate

	logic [7:0] reverse_mode_control;
	logic [7:0] reverse_mode_config;
	logic [7:0] reverse_slew_and_battery_limit;
	logic [7:0] reverse_voltage_code_a;
	logic [7:0] reverse_voltage_code_b;
	logic [7:0] low_battery_threshold;
	logic [7:0] reverse_mode_status;

	orpc_pkg::orpc_state_t state;
	orpc_pkg::orpc_state_t next_state;

	logic          base_tick;
	logic          ms_tick;
	logic          slew_step;
	logic [3:0]    slew_cnt;
	logic [3:0]    slew_div;
	logic [TW-1:0] tmr;
	logic [TW-1:0] ll_cnt;
	logic [6:0]    ov_cnt;
	logic [9:0]    active_code;
	logic [9:0]    ramp_level;
	logic          ramp_falling;
	logic          in_mode;
	logic          enter;
	logic          leave;
	logic          cutoff;
	logic          ov_expired;
	logic          ll_armed;
	logic [TW-1:0] delay_ms;
	logic [TW-1:0] ss_ms;
	logic [TW-1:0] ll_ms;
	logic [2:0]    status_code;

	// Field views
	logic       en_bit;
	logic       ovr_bit;
	logic [1:0] blim_sel;
	assign en_bit   = reverse_mode_control[orpc_pkg::CTL_ENABLE];
	assign ovr_bit  = reverse_mode_control[orpc_pkg::CTL_OVERRIDE];
	assign blim_sel = reverse_slew_and_battery_limit[orpc_pkg::SBL_BLIM_LSB +: 2];

	////////////////////////////////////////////////////////////////////
	// Register file

	// Software writes; status is built from live state, never written
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reverse_mode_control           <= orpc_pkg::RST_CONTROL;
			reverse_mode_config            <= orpc_pkg::RST_CONFIG;
			reverse_slew_and_battery_limit <= orpc_pkg::RST_SLEW_BLIM;
			reverse_voltage_code_a         <= orpc_pkg::RST_CODE_A;
			reverse_voltage_code_b         <= orpc_pkg::RST_CODE_B;
			low_battery_threshold          <= orpc_pkg::RST_LOW_BAT;
		end else if (reg_wr) begin
			unique case (reg_addr)
				orpc_pkg::ADDR_CONTROL:   reverse_mode_control <= reg_wdata;
				orpc_pkg::ADDR_CONFIG:    reverse_mode_config <= reg_wdata;
				orpc_pkg::ADDR_SLEW_BLIM: begin
					reverse_slew_and_battery_limit <= {3'h0, reg_wdata[4:0]};
				end
				orpc_pkg::ADDR_CODE_A:    reverse_voltage_code_a <= reg_wdata;
				orpc_pkg::ADDR_CODE_B:    begin
					reverse_voltage_code_b <= {6'h00, reg_wdata[1:0]};
				end
				orpc_pkg::ADDR_LOW_BAT:   begin
					low_battery_threshold <= {1'b0, reg_wdata[6:0]};
				end
				default: ;
			endcase
		end
	end

	// Status byte: state field, then the two regulation flags
	assign status_code = in_mode ? (
		(state == orpc_pkg::ST_SOFT)  ? orpc_pkg::STS_SOFT  :
		(state == orpc_pkg::ST_REG)   ? orpc_pkg::STS_REG   :
		(state == orpc_pkg::ST_RETRY) ? orpc_pkg::STS_RETRY :
		(state == orpc_pkg::ST_LLOFF) ? orpc_pkg::STS_LLOFF :
		orpc_pkg::STS_RESET) : orpc_pkg::STS_RESET;
	always_comb begin
		reverse_mode_status = 8'h00;
		reverse_mode_status[2:0] = status_code;
		reverse_mode_status[orpc_pkg::STA_OUT_CC] =
			(state == orpc_pkg::ST_REG) && out_current_over;
		reverse_mode_status[orpc_pkg::STA_BAT_CC] =
			in_mode && batt_current_over;
	end

	// Registered read mux; unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else begin
			unique case (reg_addr)
				orpc_pkg::ADDR_CONTROL:   reg_rdata <= reverse_mode_control;
				orpc_pkg::ADDR_CONFIG:    reg_rdata <= reverse_mode_config;
				orpc_pkg::ADDR_SLEW_BLIM: begin
					reg_rdata <= reverse_slew_and_battery_limit;
				end
				orpc_pkg::ADDR_CODE_A:    reg_rdata <= reverse_voltage_code_a;
				orpc_pkg::ADDR_CODE_B:    reg_rdata <= reverse_voltage_code_b;
				orpc_pkg::ADDR_LOW_BAT:   reg_rdata <= low_battery_threshold;
				orpc_pkg::ADDR_STATUS:    reg_rdata <= reverse_mode_status;
				default:                  reg_rdata <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Time base: one prescaled tick chain feeds every timer

	orpc_divider #(
		.DIV (TICK_CYCLES)
	) u_base_div (
		.clk  (clk),
		.rstn (rstn),
		.en   (1'b1),
		.tick (base_tick)
	);

	orpc_divider #(
		.DIV (MS_TICKS)
	) u_ms_div (
		.clk  (clk),
		.rstn (rstn),
		.en   (base_tick),
		.tick (ms_tick)
	);

	// Base ticks per 20 mV step for each slew setting
	always_comb begin
		unique case (reverse_slew_and_battery_limit[orpc_pkg::SBL_SLEW_LSB +: 2])
			2'h0: slew_div = 4'(orpc_pkg::STEP_UV * 1000
				/ orpc_pkg::SLEW0_UV_MS / orpc_pkg::BASE_TICK_US);
			2'h1: slew_div = 4'(orpc_pkg::STEP_UV * 1000
				/ orpc_pkg::SLEW1_UV_MS / orpc_pkg::BASE_TICK_US);
			2'h2: slew_div = 4'(orpc_pkg::STEP_UV * 1000
				/ orpc_pkg::SLEW2_UV_MS / orpc_pkg::BASE_TICK_US);
			2'h3: slew_div = 4'(orpc_pkg::STEP_UV * 1000
				/ orpc_pkg::SLEW3_UV_MS / orpc_pkg::BASE_TICK_US);
		endcase
	end

	// Slew step pulse; a setting change takes hold at the next base tick
	always_ff @(posedge clk) begin
		if (!rstn) begin
			slew_cnt  <= 4'h0;
			slew_step <= 1'b0;
		end else begin
			slew_step <= 1'b0;
			if (base_tick) begin
				if (slew_cnt + 4'h1 >= slew_div) begin
					slew_cnt  <= 4'h0;
					slew_step <= 1'b1;
				end else begin
					slew_cnt <= slew_cnt + 4'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Mode entry and exit

	assign in_mode = (state != orpc_pkg::ST_OFF);
	// Override wins over the pin; idle bit and shipping block entry
	assign enter = !high_impedance_idle && !ship_mode && en_bit
		&& (ovr_bit || !mode_request_pin_n)
		&& (blim_sel != 2'h0);
	assign leave = high_impedance_idle || !en_bit
		|| (mode_request_pin_n && !ovr_bit)
		|| ship_mode
		|| (blim_sel == 2'h0)
		|| ov_expired;

	// Cutoff compare in threshold LSBs; underflow clamps to zero
	always_comb begin
		logic [7:0] lim;
		lim = {1'b0, low_battery_threshold[6:0]}
			- {5'h00, reverse_mode_config[orpc_pkg::CFG_CUT_LSB +: 3]};
		cutoff = !lim[7] && ({1'b0, battery_level} < lim);
	end

	// Millisecond figures chosen by the delay fields
	always_comb begin
		unique case (reverse_mode_control[orpc_pkg::CTL_DLY_LSB +: 2])
			2'h0: delay_ms = TW'(orpc_pkg::DLY0_MS);
			2'h1: delay_ms = TW'(orpc_pkg::DLY1_MS);
			2'h2: delay_ms = TW'(orpc_pkg::DLY2_MS);
			2'h3: delay_ms = TW'(orpc_pkg::DLY3_MS);
		endcase
		unique case (reverse_mode_control[orpc_pkg::CTL_SS_LSB +: 2])
			2'h0: ss_ms = TW'(orpc_pkg::SS0_MS);
			2'h1: ss_ms = TW'(orpc_pkg::SS1_MS);
			2'h2: ss_ms = TW'(orpc_pkg::SS2_MS);
			2'h3: ss_ms = TW'(orpc_pkg::SS3_MS);
		endcase
		unique case (reverse_mode_config[orpc_pkg::CFG_LLD_LSB +: 2])
			2'h0: ll_ms = TW'(orpc_pkg::LL0_MS);
			2'h1: ll_ms = TW'(orpc_pkg::LL1_MS);
			2'h2: ll_ms = TW'(orpc_pkg::LL2_MS);
			2'h3: ll_ms = TW'(orpc_pkg::LL2_MS);
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// State machine

	assign ll_armed = reverse_mode_control[orpc_pkg::CTL_LL_EN]
		&& buck_mode && vbat_above_vin && vout_below_6v
		&& (state == orpc_pkg::ST_REG);

	always_comb begin
		next_state = state;
		if (state == orpc_pkg::ST_OFF) begin
			if (enter) begin
				next_state = orpc_pkg::ST_RESET;
			end
		end else if (leave) begin
			next_state = orpc_pkg::ST_OFF;
		end else begin
			unique case (state)
				orpc_pkg::ST_RESET: begin
					if (!cutoff) next_state = orpc_pkg::ST_DELAY;
				end
				orpc_pkg::ST_DELAY: begin
					if (cutoff) next_state = orpc_pkg::ST_RESET;
					else if (tmr >= delay_ms) next_state = orpc_pkg::ST_SOFT;
				end
				orpc_pkg::ST_SOFT: begin
					if (cutoff) next_state = orpc_pkg::ST_RESET;
					else if (tmr >= ss_ms) next_state = orpc_pkg::ST_REG;
				end
				orpc_pkg::ST_REG: begin
					if (cutoff) next_state = orpc_pkg::ST_RESET;
					else if (vout_below_3v) begin
						next_state = orpc_pkg::ST_RETRY;
					end else if (ll_cnt > ll_ms) begin
						next_state = orpc_pkg::ST_LLOFF;
					end
				end
				orpc_pkg::ST_RETRY: begin
					if (tmr >= TW'(orpc_pkg::RETRY_OFF_MS)) begin
						next_state = orpc_pkg::ST_RESET;
					end
				end
				orpc_pkg::ST_LLOFF: next_state = orpc_pkg::ST_LLOFF;
				default: next_state = orpc_pkg::ST_OFF;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= orpc_pkg::ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// Per-state ms timer; restarts on every state change and on exit
	always_ff @(posedge clk) begin
		if (!rstn || next_state != state || !in_mode) begin
			tmr <= '0;
		end else if (ms_tick && tmr != '1) begin
			tmr <= tmr + 1'b1;
		end
	end

	// Light-load qualification; any load or disarm restarts it
	always_ff @(posedge clk) begin
		if (!rstn || !ll_armed || !load_below_5ma) begin
			ll_cnt <= '0;
		end else if (ms_tick && ll_cnt != '1) begin
			ll_cnt <= ll_cnt + 1'b1;
		end
	end

	// Overvoltage qualification; exit only once it passes 100 ms
	always_ff @(posedge clk) begin
		if (!rstn || !in_mode || !vout_over_108) begin
			ov_cnt <= 7'h00;
		end else if (ms_tick && !ov_expired) begin
			ov_cnt <= ov_cnt + 7'h01;
		end
	end
	assign ov_expired = (ov_cnt > 7'(orpc_pkg::OV_QUAL_MS));

	////////////////////////////////////////////////////////////////////
	// Output reference

	// Code is frozen in the mode unless internal feedback owns it
	always_ff @(posedge clk) begin
		if (!rstn) begin
			active_code <= {orpc_pkg::RST_CODE_B[1:0], orpc_pkg::RST_CODE_A};
		end else if (!in_mode || (internal_fb
			&& !reverse_slew_and_battery_limit[orpc_pkg::SBL_VSRC])) begin
			active_code <= {reverse_voltage_code_b[1:0],
				reverse_voltage_code_a};
		end
	end

	// Startup jumps straight to target; soft start shapes that edge
	orpc_ramp #(
		.W (10)
	) u_ramp (
		.clk     (clk),
		.rstn    (rstn),
		.load    (state == orpc_pkg::ST_RESET || !in_mode),
		.step    (slew_step),
		.target  (active_code),
		.level   (ramp_level),
		.falling (ramp_falling)
	);

	////////////////////////////////////////////////////////////////////
	// Registered outputs

	// Power stage control; overvoltage cuts switching at once
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reverse_active    <= 1'b0;
			converter_enable  <= 1'b0;
			switching_enable  <= 1'b0;
			soft_start_active <= 1'b0;
			vref_code         <= 10'h000;
		end else begin
			reverse_active    <= in_mode;
			converter_enable  <= (state == orpc_pkg::ST_SOFT)
				|| (state == orpc_pkg::ST_REG);
			switching_enable  <= ((state == orpc_pkg::ST_SOFT)
				|| (state == orpc_pkg::ST_REG)) && !vout_over_108;
			soft_start_active <= (state == orpc_pkg::ST_SOFT);
			vref_code         <= ramp_level;
		end
	end

	// Limits and compensation presented to the analog loop
	always_ff @(posedge clk) begin
		if (!rstn) begin
			current_scale_pct <= 7'h01;
			battery_limit_sel <= 2'h0;
			cord_comp_mv      <= 9'h000;
		end else begin
			if (output_current_scale == 7'h00) begin
				current_scale_pct <= 7'h01;
			end else if (output_current_scale > 7'h64) begin
				current_scale_pct <= 7'h64;
			end else begin
				current_scale_pct <= output_current_scale;
			end
			battery_limit_sel <= blim_sel;
			cord_comp_mv <= 9'(orpc_pkg::COMP_STEP_MV
				* reverse_mode_config[orpc_pkg::CFG_COMP_LSB +: 2]);
		end
	end

	// Sink holds past the ramp until the output settles
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ramp_sink_on   <= 1'b0;
			ov_pulldown_on <= 1'b0;
		end else begin
			ramp_sink_on <= in_mode
				&& reverse_mode_control[orpc_pkg::CTL_RAMP_PD]
				&& (ramp_falling || (ramp_sink_on && !vout_in_reg));
			ov_pulldown_on <= in_mode && vout_over_108
				&& reverse_mode_config[orpc_pkg::CFG_OV_PD];
		end
	end

endmodule
`default_nettype wire

/* shared/orpc_pkg.sv */
// Contract
// - High-impedance bit set blocks and forces idle
// - Override bit enters mode, beats request pin
// - Leave when enable cleared or pin+override released
// - Shipping mode ends reverse-power operation
// - Target is 2.96 V plus 20 mV per code
// - Reference ramps at selected slew, 1 to 0.1 V/ms
// - Battery below threshold minus offset forces reset state
// - Ramp-down sink on while lowering until regulated
// - Start delay 0 ms to 1 s before converter
// - Soft start time from field, voltage independent
// - Current limit is hardware limit times percent code
// - Scale zero means 1 %, above 0x64 means 100 %
// - Status bit shows output constant-current regulation
// - Output below 3 V: off 3 s, then restart
// - Battery limit field: off, 150, 200, 300 percent
// - Battery limit flag; collapse uses same retry flow
// - Overvoltage stops switching; after 100 ms exit mode
// - Cable compensation 0 to 300 mV at 2.4 A
// - Light-load shutdown armed only under four conditions
// - Low load past delay enters latched light-load state
// - Code changes apply only with internal feedback selected
// - Overvoltage pulldown when its enable bit set
// - State field reads 000 outside the mode
package orpc_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_CONTROL   = 8'h0e;
	localparam logic [7:0] ADDR_CONFIG    = 8'h0f;
	localparam logic [7:0] ADDR_SLEW_BLIM = 8'h10;
	localparam logic [7:0] ADDR_CODE_A    = 8'h13;
	localparam logic [7:0] ADDR_CODE_B    = 8'h14;
	localparam logic [7:0] ADDR_LOW_BAT   = 8'h1a;
	localparam logic [7:0] ADDR_STATUS    = 8'h20;

	// Control register fields
	localparam int CTL_ENABLE   = 0;
	localparam int CTL_OVERRIDE = 1;
	localparam int CTL_SS_LSB   = 2;
	localparam int CTL_LL_EN    = 4;
	localparam int CTL_DLY_LSB  = 5;
	localparam int CTL_RAMP_PD  = 7;
	// Config register fields
	localparam int CFG_CUT_LSB  = 0;
	localparam int CFG_COMP_LSB = 3;
	localparam int CFG_LLD_LSB  = 5;
	localparam int CFG_OV_PD    = 7;
	// Slew / battery limit register fields
	localparam int SBL_SLEW_LSB = 0;
	localparam int SBL_BLIM_LSB = 2;
	localparam int SBL_VSRC     = 4;
	// Status register fields
	localparam int STA_OUT_CC   = 3;
	localparam int STA_BAT_CC   = 4;

	// Reset values
	localparam logic [7:0] RST_CONTROL   = 8'h00;
	localparam logic [7:0] RST_CONFIG    = 8'h00;
	localparam logic [7:0] RST_SLEW_BLIM = 8'h04;
	localparam logic [7:0] RST_CODE_A    = 8'h6b;
	localparam logic [7:0] RST_CODE_B    = 8'h00;
	localparam logic [7:0] RST_LOW_BAT   = 8'h00;

	// State field codes
	localparam logic [2:0] STS_RESET  = 3'h0;
	localparam logic [2:0] STS_SOFT   = 3'h1;
	localparam logic [2:0] STS_REG    = 3'h2;
	localparam logic [2:0] STS_RETRY  = 3'h3;
	localparam logic [2:0] STS_LLOFF  = 3'h4;

	// Timing: base tick, slew steps and millisecond timers
	localparam int CLK_MHZ       = 25;
	localparam int BASE_TICK_US  = 20;
	localparam int BASE_TICK_CYC = CLK_MHZ * BASE_TICK_US;
	localparam int MS_PER_TICKS  = 1000 / BASE_TICK_US;
	localparam int STEP_UV       = 20000;
	localparam int SLEW0_UV_MS   = 1000000;
	localparam int SLEW1_UV_MS   = 500000;
	localparam int SLEW2_UV_MS   = 200000;
	localparam int SLEW3_UV_MS   = 100000;
	localparam int OV_QUAL_MS    = 100;
	localparam int RETRY_OFF_MS  = 3000;
	localparam int DLY0_MS = 0, DLY1_MS = 100, DLY2_MS = 500, DLY3_MS = 1000;
	localparam int SS0_MS  = 1, SS1_MS  = 2,   SS2_MS  = 4,   SS3_MS  = 8;
	localparam int LL0_MS  = 10000, LL1_MS = 20000, LL2_MS = 30000;
	localparam int COMP_STEP_MV  = 100;

	typedef enum logic [2:0] {
		ST_OFF, ST_RESET, ST_DELAY, ST_SOFT, ST_REG, ST_RETRY, ST_LLOFF
	} orpc_state_t;

endpackage

/* verilog/orpc_divider.sv */
`timescale 1ns/1ns
`default_nettype none
module orpc_divider #(
	parameter int DIV = 500
) (
	input  wire logic clk,   // System clock
	input  wire logic rstn,  // Synchronous reset, active low
	input  wire logic en,    // Count enable
	output logic      tick   // One-cycle pulse every DIV enables
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	logic [CW-1:0] cnt;
	generate
		if (DIV < 1) begin : g_bad
			$error("orpc_divider: DIV must be at least 1");
		end
	endgenerate
	////////////////////////////////////////////////////////////////////
	// Free counter; the pulse is registered so callers see a clean flop
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (en) begin
				if (cnt == CW'(DIV - 1)) begin
					cnt  <= '0;
					tick <= 1'b1;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* verilog/orpc_ramp.sv */
`timescale 1ns/1ns
`default_nettype none
module orpc_ramp #(
	parameter int W = 10
) (
	input  wire logic         clk,     // System clock
	input  wire logic         rstn,    // Synchronous reset, active low
	input  wire logic         load,    // Jump straight to target
	input  wire logic         step,    // Move one code toward target
	input  wire logic [W-1:0] target,  // Code to reach
	output logic      [W-1:0] level,   // Present reference code
	output logic              falling  // Level still above target
);
	generate
		if (W < 1) begin : g_bad
			$error("orpc_ramp: W must be at least 1");
		end
	endgenerate
	////////////////////////////////////////////////////////////////////
	// One code per step keeps the slope set purely by the step rate
	always_ff @(posedge clk) begin
		if (!rstn) begin
			level <= '0;
		end else if (load) begin
			level <= target;
		end else if (step) begin
			if (level < target) begin
				level <= level + 1'b1;
			end else if (level > target) begin
				level <= level - 1'b1;
			end
		end
	end

	assign falling = (level > target);
endmodule
`default_nettype wire

/* tb/orpc_host.sv */
`timescale 1ns/1ns
`default_nettype none
module orpc_host (
	input  wire logic       clk,               // System clock
	input  wire logic [7:0] reg_rdata,         // Read data from device
	output var  logic       reg_wr,            // Write strobe
	output var  logic [7:0] reg_addr,          // Register address
	output var  logic [7:0] reg_wdata,         // Write data
	output var  logic       mode_request_pin_n // Mode request, low
);
	// Bus idle and pin released at time zero
	initial {reg_wr, reg_addr, reg_wdata, mode_request_pin_n} = 18'h00001;
	////////////////////////////////////////////////////////////////////
	// Write is a one-cycle strobe launched just after an edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk) #1;
		reg_wr = 1'b0;
	endtask
	// Data is taken one step after the edge that registers it
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) #1;
		reg_addr = a;
		@(posedge clk) #1;
		d = reg_rdata;
	endtask
	// Host asks for the mode by pulling the pin low
	task automatic pin(input logic v);
		@(posedge clk) #1 mode_request_pin_n = v;
	endtask
endmodule
`default_nettype wire

/* tb/orpc_top_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module orpc_top_sva (
	input wire logic       clk,                  // Clock
	input wire logic       rstn,                 // Reset, active low
	input wire logic       high_impedance_idle,  // Global idle bit
	input wire logic       ship_mode,            // Shipping mode
	input wire logic       vout_over_108,        // Overvoltage
	input wire logic [6:0] output_current_scale, // Scaling code
	input wire logic       reverse_active,       // In mode
	input wire logic       converter_enable,     // Stage enabled
	input wire logic       switching_enable,     // Switching allowed
	input wire logic       soft_start_active,    // Soft start
	input wire logic [6:0] current_scale_pct,    // Effective percent
	input wire logic       ov_pulldown_on        // Overvoltage pulldown
);
	// All checks share the one clock and its reset
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////
	idle_forces_off_a: assert property (
		high_impedance_idle [*3] |-> !reverse_active) else $error("idle");
	entry_not_idle_a: assert property (
		$rose(reverse_active) |-> !$past(high_impedance_idle, 2))
		else $error("entered while idle");
	ship_forces_off_a: assert property (
		ship_mode [*3] |-> !reverse_active) else $error("ship ignored");
	conv_in_mode_a: assert property (
		converter_enable |-> reverse_active) else $error("stage on");
	soft_needs_conv_a: assert property (
		soft_start_active |-> converter_enable) else $error("soft start");
	ov_stops_switch_a: assert property (
		vout_over_108 |=> !switching_enable) else $error("ov switching");
	ov_pulldown_cause_a: assert property (
		ov_pulldown_on |-> $past(vout_over_108)) else $error("pulldown");
	scale_clamp_a: assert property (
		1'b1 |=> current_scale_pct == ($past(output_current_scale) == 7'h00
		? 7'h01 : $past(output_current_scale) > 7'h64 ? 7'h64
		: $past(output_current_scale))) else $error("scale");
endmodule
bind orpc_top orpc_top_sva chk_i (.clk, .rstn, .high_impedance_idle,
	.ship_mode, .vout_over_108, .output_current_scale, .reverse_active,
	.converter_enable, .switching_enable, .soft_start_active,
	.current_scale_pct, .ov_pulldown_on);
`default_nettype wire

/* tb/orpc_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module orpc_top_bench;
	logic clk, rstn, high_impedance_idle, ship_mode, internal_fb, buck_mode;
	logic vout_below_3v, vout_over_108, vout_in_reg, out_current_over;
	logic vout_below_6v, vbat_above_vin, load_below_5ma, batt_current_over;
	logic [6:0] output_current_scale, battery_level;
	wire logic reg_wr, mode_request_pin_n, reverse_active, ramp_sink_on;
	wire logic converter_enable, switching_enable, soft_start_active;
	wire logic ov_pulldown_on;
	wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
	wire logic [9:0] vref_code;
	wire logic [6:0] current_scale_pct;
	wire logic [1:0] battery_limit_sel;
	wire logic [8:0] cord_comp_mv;
	int n_mismatch, check_count, cyc;
	logic [7:0] d;
	// Short tick so one ms is four cycles
	orpc_top #(.TICK_CYCLES(2), .MS_TICKS(2)) uut (.clk, .rstn, .reg_wr,
		.reg_addr, .reg_wdata, .reg_rdata, .high_impedance_idle, .ship_mode,
		.mode_request_pin_n, .internal_fb, .output_current_scale,
		.battery_level, .vout_below_3v, .vout_over_108, .vout_in_reg,
		.vout_below_6v, .buck_mode, .vbat_above_vin, .load_below_5ma,
		.out_current_over, .batt_current_over,
		.reverse_active, .converter_enable, .switching_enable,
		.soft_start_active, .vref_code, .current_scale_pct,
		.battery_limit_sel, .cord_comp_mv, .ramp_sink_on, .ov_pulldown_on);
	orpc_host host (.clk, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata,
		.mode_request_pin_n);
	////////////////////////////////////////////////////////////////////
	// Free-running 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Hang guard, above the retry wait plus the light-load wait
	always @(posedge clk) begin
		cyc++;
		if (cyc == 70000) begin
			n_mismatch++;
			close_out;
		end
	end
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Bounded wait for mode (s=0) or stage (s=1) to reach v
	task automatic wt(input int s, input logic v, input int n);
		for (int i = 0; i < n && (s ? converter_enable : reverse_active) !== v;
				i++)
			@(posedge clk) #1;
		chk(s ? converter_enable : reverse_active, v);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// Reset values, an unmapped hole and the code's top bits
	task automatic t_regs;
		logic [7:0] a [7] = '{8'h0e, 8'h0f, 8'h10, 8'h13, 8'h14, 8'h1a, 8'h11};
		logic [7:0] e [7] = '{8'h00, 8'h00, 8'h04, 8'h6b, 8'h00, 8'h00, 8'h00};
		foreach (a[i]) begin
			host.rd(a[i], d);
			chk(d, e[i]);
		end
		host.wr(8'h14, 8'hff);
		host.rd(8'h14, d);
		chk(d, 8'h03);
	endtask
	// Override enters with the pin high; clearing enable leaves
	task automatic t_override;
		host.wr(8'h0e, 8'h03);
		wt(0, 1'b1, 20);
		wt(1, 1'b1, 20);
		chk(soft_start_active, 1'b1);
		repeat (10) @(posedge clk) #1;
		chk(soft_start_active, 1'b0);
		host.wr(8'h0e, 8'h00);
		wt(0, 1'b0, 10);
	endtask
	// Pin entry, then idle, ship and a zero limit field each force exit
	task automatic t_pin;
		host.wr(8'h0e, 8'h11);
		host.pin(1'b0);
		wt(0, 1'b1, 20);
		@(posedge clk) #1 high_impedance_idle = 1'b1;
		wt(0, 1'b0, 10);
		@(posedge clk) #1 high_impedance_idle = 1'b0;
		wt(0, 1'b1, 20);
		@(posedge clk) #1 ship_mode = 1'b1;
		wt(0, 1'b0, 10);
		@(posedge clk) #1 ship_mode = 1'b0;
		wt(0, 1'b1, 20);
		host.wr(8'h10, 8'h00);
		wt(0, 1'b0, 10);
		host.wr(8'h10, 8'h04);
		host.pin(1'b1);
	endtask
	task automatic t_scale;
		logic [6:0] v [3] = '{7'h00, 7'h7f, 7'h32};
		logic [6:0] e [3] = '{7'h01, 7'h64, 7'h32};
		foreach (v[i]) begin
			@(posedge clk) #1 output_current_scale = v[i];
			repeat (2) @(posedge clk) #1;
			chk(current_scale_pct, e[i]);
		end
	endtask
	// Overvoltage stops switching now, leaves the mode after 100 ms
	task automatic t_ov;
		host.wr(8'h0f, 8'h98);
		host.pin(1'b0);
		wt(1, 1'b1, 40);
		chk(cord_comp_mv, 9'h12c);
		@(posedge clk) #1 vout_over_108 = 1'b1;
		repeat (2) @(posedge clk) #1;
		chk(switching_enable, 1'b0);
		chk(ov_pulldown_on, 1'b1);
		repeat (300) @(posedge clk) #1;
		chk(reverse_active, 1'b1);
		wt(0, 1'b0, 200);
		host.pin(1'b1);
		vout_over_108 = 1'b0;
	endtask
	// Collapse retry, both limit flags, then light-load latch-off
	task automatic t_retry;
		host.pin(1'b0);
		wt(1, 1'b1, 40);
		repeat (10) @(posedge clk) #1;
		vout_below_3v = 1'b1;
		wt(1, 1'b0, 10);
		host.rd(8'h20, d);
		chk(d, 8'h03);
		vout_below_3v = 1'b0;
		repeat (11000) @(posedge clk) #1;
		chk(converter_enable, 1'b0);
		wt(1, 1'b1, 2000);
		repeat (10) @(posedge clk) #1;
		{out_current_over, batt_current_over} = 2'h3;
		host.rd(8'h20, d);
		chk(d, 8'h1a);
		{buck_mode, vbat_above_vin, load_below_5ma} = 3'h7;
		wt(1, 1'b0, 41000);
		host.rd(8'h20, d);
		chk(d, 8'h14);
		host.pin(1'b1);
		wt(0, 1'b0, 10);
		host.rd(8'h20, d);
		chk(d, 8'h00);
	endtask
	// Main sequence: six reset cycles, then each scenario in turn
	initial begin
		{rstn, high_impedance_idle, ship_mode, vout_below_3v} = 4'h0;
		{vout_over_108, out_current_over, batt_current_over} = 3'h0;
		{internal_fb, vout_in_reg, vout_below_6v} = 3'h7;
		{buck_mode, vbat_above_vin, load_below_5ma} = 3'h0;
		output_current_scale = 7'h64;
		battery_level = 7'h7f;
		repeat (6) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (2) @(posedge clk) #1;
		chk(vref_code, 10'h06b);
		t_regs;
		t_override;
		t_pin;
		t_scale;
		t_ov;
		t_retry;
		close_out;
	end
endmodule
`default_nettype wire
